// >>> src/lane_ack.sv
`timescale 1ns/1ps
// ----------------------------------------
// Lane step FIFO
// ----------------------------------------
module lane_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rstn,
	// Write side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output      logic             in_ready,
	// Read side
	output      logic [WIDTH-1:0] out_data,
	output      logic             out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             ready_reg;
	logic             push;
	logic             pop;

	// Ready is registered so that the top-level ready output comes from a flip-flop
	assign in_ready  = ready_reg;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_next;
			ready_reg <= (count_next != (AW+1)'(DEPTH));
		end
	end
endmodule // lane_fifo

// ----------------------------------------
// Local command and lane acknowledge slice
// ----------------------------------------
module lane_ack #(
	parameter bit WIDE64 = 1'b1
) (
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           rstn,
	// Address phase from the bus side
	input  wire lane_ack_pkg::addr_phase_t      addr_phase,
	input  wire logic                           addr_phase_valid,
	input  wire lane_ack_pkg::xfer_kind_t       xfer_kind,
	input  wire logic                           target_active,
	// Lane steps of 32-bit transfers
	input  wire logic                           word_valid,
	output      logic                           word_ready,
	input  wire logic                           word_high_lane,
	input  wire logic                           word_first,
	input  wire logic                           xfer_is_32,
	input  wire logic                           xfer_active,
	// Local side
	output      logic                           local_target_frame_n,
	output      logic [lane_ack_pkg::CMD_W-1:0] local_cmd,
	output      logic                           low_lane_ack_n,
	output      logic                           high_lane_ack_n,
	input  wire logic                           local_ready
);
	import lane_ack_pkg::*;

	lane_word_t in_word;
	lane_word_t out_word;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic       step;
	logic       addr_high_reg;
	logic       low_next;
	logic       high_next;

	function automatic logic is_aligned(input logic [2:0] low_bits);
		return low_bits == ALIGN_LOW;
	endfunction

	// ----------------------------------------
	// Address phase capture
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			local_cmd            <= CMD_RESET;
			local_target_frame_n <= 1'b1;
			addr_high_reg        <= 1'b0;
		end else begin
			if (addr_phase_valid && target_active) begin
				local_cmd            <= addr_phase.cmd;
				local_target_frame_n <= 1'b0;
				addr_high_reg        <= (addr_phase.addr[2:0] == ALIGN_HIGH);
			end else if (!target_active) begin
				local_target_frame_n <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Lane step buffering
	// ----------------------------------------
	assign in_word.kind      = xfer_kind;
	assign in_word.high_lane = word_high_lane;
	assign in_word.first     = word_first;
	assign word_ready        = fifo_in_ready;
	assign step              = fifo_out_valid && local_ready;

	lane_fifo #(
		.WIDTH ($bits(lane_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rstn      (rstn),
		.in_data   (in_word),
		.in_valid  (word_valid && xfer_is_32 && xfer_active),
		.in_ready  (fifo_in_ready),
		.out_data  (out_word),
		.out_valid (fifo_out_valid),
		.out_ready (local_ready)
	);

	// ----------------------------------------
	// Lane acknowledge decode
	// ----------------------------------------
	always_comb begin
		low_next  = 1'b1;
		high_next = 1'b1;
		if (step) begin
			case (out_word.kind)
				XFER_TGT_WRITE, XFER_MST_READ: begin
					low_next  = out_word.high_lane;
					high_next = !out_word.high_lane;
				end
				XFER_TGT_READ: begin
					if (out_word.first) begin
						low_next  = !is_aligned({addr_high_reg, 2'b00});
						high_next = is_aligned({addr_high_reg, 2'b00});
					end
				end
				default: begin
					low_next  = 1'b1;
					high_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			low_lane_ack_n  <= 1'b1;
			high_lane_ack_n <= 1'b1;
		end else if (!WIDE64) begin
			low_lane_ack_n  <= 1'b1;
			high_lane_ack_n <= 1'b1;
		end else begin
			low_lane_ack_n  <= low_next;
			high_lane_ack_n <= high_next || !low_next;
		end
	end
endmodule // lane_ack

// >>> src/lane_ack_pkg.sv
package lane_ack_pkg;

	localparam int         CMD_W        = 4;
	localparam int         ADDR_W       = 64;
	localparam logic [2:0] ALIGN_LOW    = 3'h0;
	localparam logic [2:0] ALIGN_HIGH   = 3'h4;
	localparam logic [3:0] CMD_RESET    = 4'h0;
	localparam int         FIFO_DEPTH   = 8;

	typedef enum logic [1:0] {
		XFER_TGT_WRITE = 2'b00,
		XFER_TGT_READ  = 2'b01,
		XFER_MST_READ  = 2'b10,
		XFER_OTHER     = 2'b11
	} xfer_kind_t;

	// Address phase capture from the bus side
	typedef struct packed {
		logic [CMD_W-1:0]  cmd;
		logic [ADDR_W-1:0] addr;
	} addr_phase_t;

	// One 32-bit lane step queued toward the local side
	typedef struct packed {
		xfer_kind_t kind;
		logic       high_lane;
		logic       first;
	} lane_word_t;

endpackage

// >>> verif/lane_ack_bench.sv
`timescale 1ns/1ps
module lane_ack_bench;
	import lane_ack_pkg::*;
	logic clock = 0, rstn = 1, addr_phase_valid = 0, target_active = 0, word_valid = 0, word_high_lane = 0;
	logic word_first = 0, xfer_is_32 = 1, xfer_active = 1, stall = 0, word_ready, local_ready;
	logic local_target_frame_n, low_lane_ack_n, high_lane_ack_n;
	logic [CMD_W-1:0] local_cmd;
	addr_phase_t addr_phase = '0;
	xfer_kind_t xfer_kind = XFER_OTHER;
	logic [2:0] cap_low = 0;
	logic [1:0] exp_q[$];
	int n_errors = 0, n_compared = 0, cyc = 0, i;
	always #10 clock = ~clock;
	lane_ack i_lane_ack (.*);
	local_peer i_local_peer (.*);
	task automatic check(input logic [3:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic push(input xfer_kind_t k, input logic h, f);
		xfer_kind = k;
		word_high_lane = h;
		word_first = f;
		word_valid = 1;
		while (!word_ready) @(posedge clock) #1;
		@(posedge clock) #1;
		if (xfer_is_32 && (k == XFER_TGT_WRITE || k == XFER_MST_READ || (k == XFER_TGT_READ && f)))
			exp_q.push_back((k == XFER_TGT_READ ? cap_low == ALIGN_HIGH : h) ? 2'b10 : 2'b01);
	endtask
	always @(negedge clock) begin
		if (rstn && {low_lane_ack_n, high_lane_ack_n} !== 2'b11)
			check({low_lane_ack_n, high_lane_ack_n}, exp_q.size() ? exp_q.pop_front() : 2'b11);
		if (++cyc == 20000) begin
			n_errors++;
			stop_test;
		end
	end
	initial begin
		void'($urandom(44));
		rstn = 0;
		repeat (16) @(posedge clock);
		#1 rstn = 1;
		for (i = 0; i < 64; i++) begin
			if (i % 16 == 0) begin
				word_valid = 0;
				target_active = 0;
				wait (exp_q.size() == 0);
				repeat (20) @(posedge clock);
				#1 addr_phase = {4'($urandom), 32'($urandom), 29'($urandom), i[4], 2'b00};
				cap_low = addr_phase.addr[2:0];
				addr_phase_valid = 1;
				target_active = 1;
				@(posedge clock) #1 addr_phase_valid = 0;
				check(local_cmd, addr_phase.cmd);
			end
			xfer_is_32 = $urandom_range(4) != 0;
			push(xfer_kind_t'(i[1:0]), i[2], i[3]);
		end
		word_valid = 0;
		xfer_is_32 = 1;
		wait (exp_q.size() == 0);
		repeat (20) @(posedge clock);
		#1 stall = 1;
		repeat (2) @(posedge clock);
		#1;
		for (i = 0; i < 8; i++)
			push(XFER_MST_READ, i[0], 0);
		check(word_ready, 0);
		stall = 0;
		push(XFER_TGT_WRITE, 1, 0);
		word_valid = 0;
		wait (exp_q.size() == 0);
		repeat (4) @(posedge clock);
		stop_test;
	end
endmodule // lane_ack_bench

// >>> verif/lane_ack_monitor.sv
`timescale 1ns/1ps
module lane_ack_monitor import lane_ack_pkg::*; #(parameter bit WIDE64 = 1'b1) (
	input wire logic clock, rstn, addr_phase_valid, target_active, local_ready,
	input wire addr_phase_t addr_phase,
	input wire logic [CMD_W-1:0] local_cmd,
	input wire logic local_target_frame_n, low_lane_ack_n, high_lane_ack_n
);
	wire logic cap = addr_phase_valid && target_active;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_cmd_capture: assert property (cap |=> local_cmd == $past(addr_phase.cmd)) else $error("cmd");
	a_cmd_hold: assert property (!cap |=> $stable(local_cmd)) else $error("cmd moved");
	a_frame_valid: assert property (cap |=> !local_target_frame_n) else $error("frame");
	a_frame_release: assert property (!target_active |=> local_target_frame_n) else $error("release");
	a_lanes_exclusive: assert property (low_lane_ack_n || high_lane_ack_n) else $error("both");
	a_narrow_quiet: assert property (!WIDE64 |-> low_lane_ack_n && high_lane_ack_n) else $error("narrow");
	a_low_from_pop: assert property (!low_lane_ack_n |-> $past(local_ready)) else $error("low");
	a_high_from_pop: assert property (!high_lane_ack_n |-> $past(local_ready)) else $error("high");
endmodule // lane_ack_monitor

bind lane_ack lane_ack_monitor #(.WIDE64(WIDE64)) i_lane_ack_monitor (.*);

// >>> verif/local_peer.sv
`timescale 1ns/1ps
module local_peer (
	input wire logic clock, rstn, stall,
	output logic local_ready
);
	// Drains with random slow cycles; never ready from the clock edge after stall is set until the edge after it clears
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			local_ready <= 1'b0;
		else
			local_ready <= !stall && $urandom_range(3) != 0;
	end
endmodule // local_peer
